//--- design/ahbi_host.sv
// Host controller that runs the converter through its pins
`timescale 1ns/1ps

module ahbi_host (
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   input  wire logic       go_i,
   input  wire logic [2:0] channel_i,
   input  wire logic       use_irq_i,
   input  wire logic       conv_done_i,
   input  wire logic [7:0] conv_data_i,
   output logic            conv_clk_o,
   output logic [2:0]      conv_channel_o,
   output logic            conv_latch_o,
   output logic            conv_start_o,
   output logic            conv_oe_o,
   output logic            irq_n_o,
   output logic [7:0]      result_o,
   output logic            result_valid_o,
   output logic            busy_o
);
   // ==========================================================
   // Converter clock divider
   logic [7:0] div_cnt, next_div_cnt;
   logic       conv_clk, next_conv_clk;
   logic       conv_tick;

   always_comb begin
      next_div_cnt  = div_cnt + 8'h01;
      next_conv_clk = conv_clk;
      conv_tick     = 1'b0;
      if (div_cnt == ahbi_pkg::CONV_DIV) begin
         next_div_cnt  = 8'h00;
         next_conv_clk = ~conv_clk;
         conv_tick     = ~conv_clk;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_cnt  <= 8'h00;
         conv_clk <= 1'b0;
      end else begin
         div_cnt  <= next_div_cnt;
         conv_clk <= next_conv_clk;
      end
   end

   // ==========================================================
   // Status port view of the done line
   // fixed ports, no overlap
   function automatic logic [7:0] status_word(input logic done);
      status_word = {7'h00, ~done} & ahbi_pkg::DONE_MASK;
   endfunction

   // Last cycle of a timed strobe, shared by every strobe state
   function automatic logic last_beat(input logic [7:0] count);
      last_beat = (count == 8'h01);
   endfunction

   // ==========================================================
   // Sequencer
   ahbi_pkg::ahbi_state_t state, next_state;
   logic [7:0] len, next_len;
   logic [3:0] wait_cnt, next_wait_cnt;
   logic [2:0] chan, next_chan;
   logic       irq_mode, next_irq_mode;
   logic       irq_ff;
   logic [7:0] status;

   always_comb begin
      next_state    = state;
      next_len      = len;
      next_wait_cnt = wait_cnt;
      next_chan     = chan;
      next_irq_mode = irq_mode;
      case (state)
         ahbi_pkg::AHBI_IDLE: begin
            if (go_i) begin
               next_chan     = channel_i;
               next_irq_mode = use_irq_i;
               next_len      = ahbi_pkg::STROBE_LEN;
               next_state    = ahbi_pkg::AHBI_START1;
            end
         end

         ahbi_pkg::AHBI_START1: begin
            next_len = len - 8'h01;
            if (last_beat(len)) begin
               next_len   = ahbi_pkg::STROBE_LEN;
               next_state = ahbi_pkg::AHBI_START2;
            end
         end

         ahbi_pkg::AHBI_START2: begin
            next_len = len - 8'h01;
            if (last_beat(len)) begin
               next_wait_cnt = ahbi_pkg::DONE_WAIT;
               next_state    = ahbi_pkg::AHBI_WAIT;
            end
         end

         ahbi_pkg::AHBI_WAIT: begin
            if (conv_tick)
               next_wait_cnt = wait_cnt - 4'h1;
            if (wait_cnt == 4'h0)
               next_state = irq_mode ? ahbi_pkg::AHBI_IRQ
                                     : ahbi_pkg::AHBI_POLL;
         end

         ahbi_pkg::AHBI_POLL: begin
            if (status == 8'h00) begin
               next_len   = ahbi_pkg::STROBE_LEN;
               next_state = ahbi_pkg::AHBI_READ;
            end
         end

         ahbi_pkg::AHBI_IRQ: begin
            if (irq_ff) begin
               next_len   = ahbi_pkg::STROBE_LEN;
               next_state = ahbi_pkg::AHBI_READ;
            end
         end

         ahbi_pkg::AHBI_READ: begin
            next_len = len - 8'h01;
            if (last_beat(len))
               next_state = ahbi_pkg::AHBI_IDLE;
         end

         default: next_state = ahbi_pkg::AHBI_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state    <= ahbi_pkg::AHBI_IDLE;
         len      <= 8'h00;
         wait_cnt <= 4'h0;
         chan     <= 3'h0;
         irq_mode <= 1'b0;
      end else begin
         state    <= next_state;
         len      <= next_len;
         wait_cnt <= next_wait_cnt;
         chan     <= next_chan;
         irq_mode <= next_irq_mode;
      end
   end

   // ==========================================================
   // Status read: done is looked at only while polling; outside
   // the poll it reads as not ready, so a stale done never counts
   logic [7:0] next_status;

   always_comb begin
      next_status = ahbi_pkg::DONE_MASK;
      if (state == ahbi_pkg::AHBI_POLL)
         next_status = status_word(conv_done_i);
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         status <= ahbi_pkg::DONE_MASK;
      else
         status <= next_status;
   end

   // ==========================================================
   // Converter strobes. Latch and start share one source so the
   // channel is always captured by the pulse that starts the run
   logic latch, next_latch;
   logic start, next_start;
   logic oe, next_oe;

   always_comb begin
      next_latch = 1'b0;
      next_start = 1'b0;
      next_oe    = 1'b0;
      if (state == ahbi_pkg::AHBI_START1 ||
          state == ahbi_pkg::AHBI_START2) begin
         next_latch = 1'b1;
         next_start = 1'b1;
      end
      if (state == ahbi_pkg::AHBI_READ && !last_beat(len))
         next_oe = 1'b1;
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         latch <= 1'b0;
         start <= 1'b0;
         oe    <= 1'b0;
      end else begin
         latch <= next_latch;
         start <= next_start;
         oe    <= next_oe;
      end
   end

   // ==========================================================
   // Interrupt flop: set on done in AHBI_IRQ, cleared by the
   // read. Set is written last so a completion is never lost
   logic next_irq_ff;
   logic irq_n, next_irq_n;

   always_comb begin
      next_irq_ff = irq_ff;
      if (state == ahbi_pkg::AHBI_READ && last_beat(len))
         next_irq_ff = 1'b0;
      if (irq_mode && state == ahbi_pkg::AHBI_IRQ && conv_done_i)
         next_irq_ff = 1'b1;
      next_irq_n = ~next_irq_ff;
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_ff <= 1'b0;
         irq_n  <= 1'b1;
      end else begin
         irq_ff <= next_irq_ff;
         irq_n  <= next_irq_n;
      end
   end

   // ==========================================================
   // Result register. The bus is taken on the last gate cycle,
   // when the converter has had longest to drive it
   logic [7:0] result, next_result;
   logic       rvalid, next_rvalid;

   always_comb begin
      next_result = result;
      next_rvalid = 1'b0;
      if (state == ahbi_pkg::AHBI_READ && last_beat(len)) begin
         next_result = conv_data_i;
         next_rvalid = 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         result <= 8'h00;
         rvalid <= 1'b0;
      end else begin
         result <= next_result;
         rvalid <= next_rvalid;
      end
   end

   // ==========================================================
   // Busy is registered from next_state so it lines up with state, one cycle ahead of the strobes
   logic busy, next_busy;

   always_comb begin
      next_busy = (next_state != ahbi_pkg::AHBI_IDLE);
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         busy <= 1'b0;
      else
         busy <= next_busy;
   end

   // ==========================================================
   // Outputs, each straight from a flop
   assign conv_clk_o     = conv_clk;
   assign conv_channel_o = chan;
   assign conv_latch_o   = latch;
   assign conv_start_o   = start;
   assign conv_oe_o      = oe;
   assign irq_n_o        = irq_n;
   assign result_o       = result;
   assign result_valid_o = rvalid;
   assign busy_o         = busy;
endmodule // ahbi_host

//--- design/ahbi_pkg.sv
// Constants shared by the converter host bus interface
package ahbi_pkg;
   // ==========================================================
   // Port map as seen by the host (I/O space)
   localparam logic [7:0] DATA_PORT   = 8'h00;
   localparam logic [7:0] STATUS_PORT = 8'h40;
   localparam logic [7:0] DONE_MASK   = 8'h01;
   // ==========================================================
   // Converter clock divider, 100 MHz down to converter rate
   localparam int          CLK_HZ       = 100000000;
   localparam int          CONV_HZ      = 500000;
   localparam logic [7:0]  CONV_DIV     = 8'(CLK_HZ / CONV_HZ / 2 - 1);
   // Least converter clocks from start to first status sample
   localparam logic [3:0]  DONE_WAIT    = 4'h8;
   // Strobe widths in system clocks
   localparam logic [7:0]  STROBE_LEN   = 8'(CLK_HZ / CONV_HZ);
   // ==========================================================
   // Sequencer states, Gray coded along the usual path
   typedef enum logic [3:0] {
      AHBI_IDLE   = 4'h0,
      AHBI_START1 = 4'h1,
      AHBI_START2 = 4'h3,
      AHBI_WAIT   = 4'h2,
      AHBI_POLL   = 4'h6,
      AHBI_READ   = 4'h7,
      AHBI_IRQ    = 4'h5
   } ahbi_state_t;
endpackage

//--- testbench/ahbi_checker.sv
// Assertion checker for the converter host controller
`timescale 1ns/1ps
module ahbi_checker (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic go_i,
   input wire logic conv_done_i,
   input wire logic conv_latch_o,
   input wire logic conv_start_o,
   input wire logic conv_oe_o,
   input wire logic irq_n_o,
   input wire logic result_valid_o,
   input wire logic busy_o
);
   // ===
   // Cycles since strobes fell, saturating so idle spans never wrap
   logic [15:0] gap;
   always_ff @(posedge mclk_i or negedge rst_n_i)
      if (!rst_n_i) gap <= 16'h0;
      else gap <= conv_start_o ? 16'h0 : gap + 16'(gap != 16'hffff);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   property p_pair; conv_latch_o == conv_start_o; endproperty
   a_pair: assert property (p_pair) else $error("strobes");
   property p_go; !busy_o && go_i |=> busy_o ##1 conv_start_o; endproperty
   a_go: assert property (p_go) else $error("no start");
   property p_wait; $rose(conv_oe_o) |-> gap > 16'h0578; endproperty
   a_wait: assert property (p_wait) else $error("early read");
   property p_oe; $rose(conv_oe_o) |-> $past(conv_done_i); endproperty
   a_oe: assert property (p_oe) else $error("not done");
   property p_set; $fell(irq_n_o) |-> $past(conv_done_i); endproperty
   a_set: assert property (p_set) else $error("stray irq");
   property p_clr; result_valid_o |-> irq_n_o && !conv_oe_o; endproperty
   a_clr: assert property (p_clr) else $error("irq held");
   property p_read; $fell(conv_oe_o) |-> result_valid_o; endproperty
   a_read: assert property (p_read) else $error("no result");
   property p_idle; $fell(busy_o) |-> result_valid_o; endproperty
   a_idle: assert property (p_idle) else $error("idle early");
endmodule // ahbi_checker
bind ahbi_host ahbi_checker ahbi_checker_inst (.mclk_i, .rst_n_i, .go_i,
   .conv_done_i, .conv_latch_o, .conv_start_o, .conv_oe_o, .irq_n_o,
   .result_valid_o, .busy_o);

//--- testbench/ahbi_conv_model.sv
// Behavioural converter facing the host controller
`timescale 1ns/1ps
module ahbi_conv_model #(
   parameter int DROP = 6,
   parameter int CONV = 10
) (
   input  wire logic       rst_n_i,
   input  wire logic       conv_clk_i,
   input  wire logic [2:0] conv_channel_i,
   input  wire logic       conv_latch_i,
   input  wire logic       conv_start_i,
   input  wire logic       conv_oe_i,
   output logic            conv_done_o,
   output logic [7:0]      conv_data_o
);
   // ===
   int         ticks;
   logic [2:0] chan;
   logic [7:0] res;
   always @(posedge conv_latch_i) chan <= conv_channel_i;
   always @(posedge conv_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ticks <= CONV;
         res <= 8'h00;
      end else if (conv_start_i) begin
         ticks <= 0;
      end else if (ticks < CONV) begin
         ticks <= ticks + 1;
         if (ticks == CONV - 1) res <= {5'h15, chan};
      end
   end
   // done drops late so early polls read stale data
   assign conv_done_o = !(ticks >= DROP && ticks < CONV);
   assign conv_data_o = conv_oe_i ? res : ~res;
endmodule // ahbi_conv_model

//--- testbench/test_ahbi_host.sv
// Self-checking bench for the converter host controller
`timescale 1ns/1ps
module test_ahbi_host;
   logic       mclk_i = 1'b0;
   logic       rst_n_i = 1'b0;
   logic       go_i = 1'b0;
   logic       use_irq_i = 1'b0;
   logic       saw_irq = 1'b0;
   logic [2:0] channel_i = 3'h0;
   logic [2:0] conv_channel_o;
   logic [7:0] conv_data_i, result_o;
   logic       conv_done_i, conv_clk_o, conv_latch_o, conv_start_o;
   logic       conv_oe_o, irq_n_o, result_valid_o, busy_o;
   int         n_errors = 0;
   int         n_compared = 0;
   ahbi_host ahbi_host_inst (.mclk_i, .rst_n_i, .go_i, .channel_i,
      .use_irq_i, .conv_done_i, .conv_data_i, .conv_clk_o, .conv_channel_o,
      .conv_latch_o, .conv_start_o, .conv_oe_o, .irq_n_o, .result_o,
      .result_valid_o, .busy_o);
   ahbi_conv_model ahbi_conv_model_inst (.rst_n_i, .conv_clk_i(conv_clk_o),
      .conv_channel_i(conv_channel_o), .conv_latch_i(conv_latch_o),
      .conv_start_i(conv_start_o), .conv_oe_i(conv_oe_o),
      .conv_done_o(conv_done_i), .conv_data_o(conv_data_i));
   // ===
   initial forever #5 mclk_i = ~mclk_i;
   always @(posedge mclk_i)
      if (go_i === 1'b1) saw_irq <= 1'b0;
      else if (irq_n_o === 1'b0) saw_irq <= 1'b1;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Optional poke raises go while busy; it must be ignored
   task automatic convert(input logic [2:0] ch, input logic irq, poke);
      @(negedge mclk_i);
      go_i = 1'b1;
      channel_i = ch;
      use_irq_i = irq;
      @(negedge mclk_i);
      go_i = 1'b0;
      for (int i = 0; i < 20000 && result_valid_o !== 1'b1; i++) begin
         go_i = poke && i == 100;
         channel_i = ~ch;
         @(negedge mclk_i);
      end
      check({7'h0, result_valid_o}, 8'h01);
      check(result_o, {5'h15, ch});
      check({5'h0, conv_channel_o}, {5'h0, ch});
      check({7'h0, saw_irq}, {7'h0, irq});
      check({7'h0, irq_n_o}, 8'h01);
   endtask
   task automatic t_reset();
      rst_n_i = 1'b0;
      repeat (4) @(negedge mclk_i);
      check({busy_o, conv_start_o, conv_latch_o, conv_oe_o, irq_n_o}, 8'h01);
      rst_n_i = 1'b1;
   endtask
   task automatic t_sweep();
      for (int c = 0; c < 8; c++) convert(3'(c), c[0], 1'b0);
   endtask
   task automatic t_abort();
      @(negedge mclk_i);
      go_i = 1'b1;
      use_irq_i = 1'b1;
      @(negedge mclk_i);
      go_i = 1'b0;
      repeat (300) @(negedge mclk_i);
      t_reset();
   endtask
   initial begin
      t_reset();
      t_sweep();
      t_abort();
      convert(3'h5, 1'b0, 1'b1);
      finish_test();
   end
   initial begin
      #700000;
      n_errors++;
      finish_test();
   end
endmodule // test_ahbi_host
